// ===== bench/cpba_peer.sv
`timescale 1ns/1ps
// ==========================================
// behavioural peer agents 1 to 3 on the shared lines
module cpba_peer (
  input wire logic CLOCK_I,
  input wire logic [3:1] CORE_I, // peer cores wanting the bus
  input wire logic [3:1] DMA_I, // peer normal dma pending
  input wire logic DUT_CPA_N_I, // core-priority share of the block
  output logic [3:1] BR_N_O, // peer request lines, low active
  output logic CPA_N_O // peers' share of core-priority, pull-up idle
);
  logic [3:1] req; // effective peer requests
  // dma peers back off while any other agent holds core priority
  always_comb begin
    for (int k = 1; k < 4; k++) begin
      req[k] = CORE_I[k] | (DMA_I[k] & DUT_CPA_N_I & ~|(CORE_I & ~(3'h1 << (k - 1))));
    end
  end
  // lines released go back to the pull-up level
  initial begin
    BR_N_O = 3'h7;
    CPA_N_O = 1'h1;
  end
  // requests registered from req each clock, core priority held while any core still waits
  always @(posedge CLOCK_I) begin
    BR_N_O <= ~req;
    CPA_N_O <= ~|CORE_I;
  end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
// ==========================================
// block as agent 0 among three behavioural peers
module tb_top;
  import cpba_pkg::*;
  logic CLOCK_I = 1'h0, NRST_I = 1'h0, core = 1'h0, dma = 1'h0, hip = 1'h0, txn = 1'h0;
  logic [3:1] p_core = 3'h0, p_dma = 3'h0; // peer stimulus
  logic [3:1] p_br_n;
  logic p_cpa_n, br_n, cpa_v, cpa_oe_n, dpa_v, dpa_oe_n, bm_n, grant, cpa_line, dpa_line;
  int err_count = 0, total_checks = 0, cycles = 0, owner = -1, last = 3;
  always #5 CLOCK_I = ~CLOCK_I;
  // wired open-drain lines with pull-ups
  assign cpa_line = p_cpa_n & (cpa_oe_n | cpa_v);
  assign dpa_line = dpa_oe_n | dpa_v;
  cpba_peer u_peer (.CLOCK_I(CLOCK_I), .CORE_I(p_core), .DMA_I(p_dma),
    .DUT_CPA_N_I(cpa_oe_n | cpa_v), .BR_N_O(p_br_n), .CPA_N_O(p_cpa_n));
  cpba_arbiter u_dut (.CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .AGENT_ID_I(2'h0), .CORE_REQ_I(core),
    .DMA_REQ_I(dma), .DMA_HIPRI_I(hip), .TXN_ACTIVE_I(txn), .BR_N_I({p_br_n, br_n}),
    .CPA_N_I(cpa_line), .DPA_N_I(dpa_line), .BR_N_O(br_n), .CPA_N_O(cpa_v),
    .CPA_OE_N_O(cpa_oe_n), .DPA_N_O(dpa_v), .DPA_OE_N_O(dpa_oe_n), .BM_N_O(bm_n),
    .GRANT_O(grant));
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one comparison
  task automatic check(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %0b seen %0b", name, exp, got);
    end
  endtask
  // let lines settle, advance the reference model, compare
  task automatic step(input int n);
    logic [3:0] req;
    repeat (n) @(negedge CLOCK_I);
    req[0] = core | (dma & ~|p_core) | (owner == 0 && txn);
    for (int k = 1; k < 4; k++) begin
      req[k] = p_core[k] | (p_dma[k] & ~core & ~|(p_core & ~(3'h1 << (k - 1))));
    end
    if (owner < 0 || !req[owner]) begin
      owner = -1;
      for (int k = 1; k < 5; k++) begin
        if (owner < 0 && req[(last + k) % 4]) owner = (last + k) % 4;
      end
      if (owner >= 0) last = owner;
    end
    check("br_n", ~req[0], br_n);
    check("cpa_oe_n", ~core, cpa_oe_n);
    check("cpa_line", ~(core | |p_core), cpa_line);
    check("dpa_oe_n", ~(dma & hip & ~|p_core), dpa_oe_n);
    check("bm_n", ~(owner == 0), bm_n);
    check("grant", owner == 0, grant);
  endtask
  // hang guard
  always @(posedge CLOCK_I) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    void'($urandom(7839));
    repeat (2) @(negedge CLOCK_I);
    NRST_I = 1'h1;
    step(3);
    core = 1'h1; step(8);
    core = 1'h0; step(8);
    dma = 1'h1; txn = 1'h1; step(8);
    p_core[1] = 1'h1; step(5 + $urandom_range(0, 20));
    txn = 1'h0; p_dma[2] = 1'h1; step(8);
    p_core[1] = 1'h0; step(10);
    p_dma[2] = 1'h0; step(10);
    hip = 1'h1; step(6);
    p_core[3:2] = 2'h3; step(10);
    p_core[2] = 1'h0; step(10);
    p_core[3] = 1'h0; step(10);
    dma = 1'h0; hip = 1'h0; step(8);
    stop_test();
  end
endmodule

// ===== rtl/cpba_arbiter.sv
`timescale 1ns/1ps
// ==========================================
// per-agent distributed bus arbitration
module cpba_arbiter (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire cpba_pkg::cpba_id_t AGENT_ID_I, // static strap
  input wire logic CORE_REQ_I, // core needs the bus
  input wire logic DMA_REQ_I, // dma transfer pending
  input wire logic DMA_HIPRI_I, // pending dma is high priority
  input wire logic TXN_ACTIVE_I, // own transaction in progress
  input wire cpba_pkg::cpba_vec_t BR_N_I, // all request lines, low active
  input wire logic CPA_N_I, // shared core-priority line level
  input wire logic DPA_N_I, // shared dma-priority line level
  output logic BR_N_O, // own request line
  output logic CPA_N_O, // core-priority drive value
  output logic CPA_OE_N_O, // core-priority enable, low drives
  output logic DPA_N_O, // dma-priority drive value
  output logic DPA_OE_N_O, // dma-priority enable, low drives
  output logic BM_N_O, // bus-master indicator
  output logic GRANT_O // own logic may use the bus
);
  import cpba_pkg::*;

  // ==========================================
  // state
  cpba_id_t id_reg; // captured agent number
  logic id_ok_reg; // strap captured
  cpba_vec_t br_meta_reg, br_sync_n_reg; // request line synchroniser
  logic cpa_meta_reg, cpa_sync_n_reg; // core-priority synchroniser
  logic dpa_meta_reg, dpa_sync_n_reg; // dma-priority synchroniser
  logic br_drive_reg, cpa_drive_reg, dpa_drive_reg; // own line drives
  cpba_id_t owner_reg, owner_next; // current master
  logic owner_valid_reg, owner_valid_next; // some agent owns the bus
  cpba_id_t last_reg, last_next; // previous master for rotation
  logic bm_n_reg; // registered master indicator

  // ==========================================
  // decode of sampled lines
  wire cpba_vec_t br_act = ~br_sync_n_reg; // active requesters
  wire cpa_line = ~cpa_sync_n_reg; // core-priority seen
  wire dpa_line = ~dpa_sync_n_reg; // dma-priority seen
  wire other_cpa = cpa_line & ~cpa_drive_reg; // someone else has core priority
  wire other_dpa = dpa_line & ~dpa_drive_reg; // someone else has dma priority
  wire granted = owner_valid_reg & (owner_reg == id_reg) & id_ok_reg; // we own
  wire hold = granted & TXN_ACTIVE_I; // keep bus to finish transaction
  wire dma_allowed = ~other_cpa & (DMA_HIPRI_I | ~other_dpa); // back-off terms
  wire owner_keeps = owner_valid_reg & br_act[owner_reg]; // master still requests
  // rotation counts from the master now letting go, or from the
  // last master when the bus sat parked, so the agent after the
  // releasing core master is served before an interrupted one
  wire cpba_id_t rot_base = owner_valid_reg ? owner_reg : last_reg;
  cpba_id_t pick; // next master by rotation
  logic pick_ok; // any requester seen

  // own request lines
  wire br_next = id_ok_reg & (hold | CORE_REQ_I | (DMA_REQ_I & dma_allowed));
  wire cpa_next = id_ok_reg & (CORE_REQ_I | (cpa_drive_reg & hold));
  wire dpa_next = id_ok_reg & ~CORE_REQ_I & DMA_REQ_I & DMA_HIPRI_I &
                  (~other_cpa | (dpa_drive_reg & hold));

  // ==========================================
  // rotating pick, first requester after the rotation base
  // the base itself is scanned first and any later hit overrides it, so a lone releasing master
  // can still win again when nobody else asks
  always_comb begin
    pick = rot_base;
    pick_ok = 1'b0;
    for (int k = CPBA_NUM_AGENTS; k >= 1; k--) begin
      // scan downward so the nearest successor is kept
      if (br_act[CPBA_ID_W'((int'(rot_base) + k) % CPBA_NUM_AGENTS)]) begin
        pick = CPBA_ID_W'((int'(rot_base) + k) % CPBA_NUM_AGENTS);
        pick_ok = 1'b1;
      end
    end
  end

  // ownership update, same in every agent
  always_comb begin
    owner_next = owner_reg;
    owner_valid_next = owner_valid_reg;
    last_next = last_reg;
    if (owner_keeps) begin
      // master keeps bus until its request drops
      owner_valid_next = 1'b1;
    end else if (pick_ok) begin
      // hand over by rotation from sampled lines
      owner_next = pick;
      owner_valid_next = 1'b1;
      // previous master becomes the rotation memory
      last_next = owner_valid_reg ? owner_reg : last_reg;
    end else begin
      // bus parked, remember last master
      owner_valid_next = 1'b0;
      last_next = owner_valid_reg ? owner_reg : last_reg;
    end
  end

  // ==========================================
  // strap capture after reset release
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      id_reg <= CPBA_ID_RST;
      id_ok_reg <= 1'b0;
    end else if (!id_ok_reg) begin
      id_reg <= AGENT_ID_I;
      id_ok_reg <= 1'b1;
    end
  end

  // two-stage synchronisers for shared pins
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      br_meta_reg <= CPBA_LINES_RST;
      br_sync_n_reg <= CPBA_LINES_RST;
      cpa_meta_reg <= CPBA_LINE_IDLE;
      cpa_sync_n_reg <= CPBA_LINE_IDLE;
      dpa_meta_reg <= CPBA_LINE_IDLE;
      dpa_sync_n_reg <= CPBA_LINE_IDLE;
    end else begin
      br_meta_reg <= BR_N_I;
      br_sync_n_reg <= br_meta_reg;
      cpa_meta_reg <= CPA_N_I;
      cpa_sync_n_reg <= cpa_meta_reg;
      dpa_meta_reg <= DPA_N_I;
      dpa_sync_n_reg <= dpa_meta_reg;
    end
  end

  // own line drives and ownership state
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      br_drive_reg <= 1'b0;
      cpa_drive_reg <= 1'b0;
      dpa_drive_reg <= 1'b0;
      owner_reg <= CPBA_ID_RST;
      owner_valid_reg <= 1'b0;
      last_reg <= CPBA_LAST_RST;
      bm_n_reg <= 1'b1;
    end else begin
      br_drive_reg <= br_next;
      cpa_drive_reg <= cpa_next;
      dpa_drive_reg <= dpa_next;
      owner_reg <= owner_next;
      owner_valid_reg <= owner_valid_next;
      last_reg <= last_next;
      bm_n_reg <= ~(owner_valid_next & (owner_next == id_reg) & id_ok_reg);
    end
  end

  // ==========================================
  // outputs
  assign BR_N_O = ~br_drive_reg; // low while requesting
  assign CPA_N_O = 1'b0; // open drain pulls low only
  assign CPA_OE_N_O = ~cpa_drive_reg;
  assign DPA_N_O = 1'b0; // open drain pulls low only
  assign DPA_OE_N_O = ~dpa_drive_reg;
  assign BM_N_O = bm_n_reg; // registered indicator
  assign GRANT_O = granted & br_drive_reg; // usable only while requesting

  // ==========================================
  // checks
  sequence s_core_ask;
    id_ok_reg && CORE_REQ_I;
  endsequence
  sequence s_core_lines;
    br_drive_reg && cpa_drive_reg && !dpa_drive_reg;
  endsequence
  sequence s_core_end;
    id_ok_reg && $fell(CORE_REQ_I) && !hold;
  endsequence

  a_core_drives_cpa: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    s_core_ask |=> s_core_lines) else $error("core request without lines");
  a_hold_until_done: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    hold |=> br_drive_reg) else $error("request dropped mid transaction");
  a_dma_backoff: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    other_cpa && !CORE_REQ_I && !hold |=> !br_drive_reg && !dpa_drive_reg)
    else $error("dma kept request under core priority");
  a_owner_kept: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    owner_keeps |=> owner_valid_reg && owner_reg == $past(owner_reg))
    else $error("bus taken from requesting master");
  a_core_over_dma: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    s_core_ask and (dpa_line || other_dpa) |=> br_drive_reg)
    else $error("core request yielded to dma");
  a_core_release: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    s_core_end ##0 (!DMA_REQ_I) |=> !br_drive_reg && !cpa_drive_reg)
    else $error("lines held after core access");
  a_rotate_next: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    !owner_keeps && pick_ok && owner_valid_reg |=> last_reg == $past(owner_reg))
    else $error("rotation not from previous master");
  a_dma_pending: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    id_ok_reg && DMA_REQ_I && !cpa_line && !dpa_line |=> br_drive_reg)
    else $error("pending dma not re-requested");
  a_master_flag: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    BM_N_O == !granted) else $error("master indicator mismatch");
  a_hipri_dpa: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    id_ok_reg && DMA_REQ_I && DMA_HIPRI_I && !CORE_REQ_I && !other_cpa
    |=> dpa_drive_reg && br_drive_reg) else $error("dma priority not driven");
  a_dpa_yields: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    other_cpa && !hold |=> !dpa_drive_reg) else $error("dma priority over core");
  a_owner_requests: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    $rose(owner_valid_reg) |-> $past(pick_ok) && owner_reg == $past(pick))
    else $error("owner chosen without request");
  // picked agent must be one that is requesting
  a_pick_requests: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    pick_ok |-> br_act[pick]) else $error("pick without request");
  // bus parks when nobody requests
  a_park_empty: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    !pick_ok && !owner_keeps |=> !owner_valid_reg) else $error("owner kept idle");
  // core priority held through own transaction
  a_cpa_waits_txn: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    cpa_drive_reg && hold |=> cpa_drive_reg) else $error("core priority cut early");
  // a core requester never shows dma priority
  a_core_no_dpa: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
    id_ok_reg && CORE_REQ_I |=> !dpa_drive_reg) else $error("dma priority with core");
endmodule

// ===== rtl/cpba_pkg.sv
package cpba_pkg;
  // ==========================================
  // cluster geometry
  localparam int CPBA_NUM_AGENTS = 4; // agents sharing the bus
  localparam int CPBA_ID_W = 2; // width of an agent number
  typedef logic [CPBA_ID_W-1:0] cpba_id_t; // agent number
  typedef logic [CPBA_NUM_AGENTS-1:0] cpba_vec_t; // one bit per agent
  // ==========================================
  // values after reset
  localparam cpba_id_t CPBA_ID_RST = 2'h0; // agent number before strap
  localparam cpba_id_t CPBA_LAST_RST = 2'h3; // rotation starts at agent 0
  localparam cpba_vec_t CPBA_LINES_RST = 4'hF; // shared lines idle high
  localparam logic CPBA_LINE_IDLE = 1'h1; // released open-drain level
endpackage
